// *** hw/device_capability.sv ***
// Read-only device capability register with a simple register port.
// Assumes one clock, strobes one cycle long, read data one cycle later.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "devcap_cfg.svh"
module device_capability
  import devcap_pkg::*;
#(
  parameter logic [2:0] MPS_CODE = `DEVCAP_MPS_RESET,
  parameter logic [2:0] L0S_CODE = `DEVCAP_L0S_RESET,
  parameter logic [2:0] L1_CODE = `DEVCAP_L1_RESET
)
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic hp_strap_i,
  input wire logic fwd_bridge_i,
  input spl_msg_t spl_msg_i,
  output logic [31:0] devcap_o
);
  // Strap results, valid from the first edge after reset release
  logic hp_en;
  logic fwd;

  // Captured slot power limit fields
  logic [7:0] spl_value;
  logic [1:0] spl_scale;

  // Static capability codes, fixed at reset
  cap_cfg_t cfg_r;
  cap_cfg_t cfg_nxt;

  // Presence bits, registered from the captured straps
  logic button_r;
  logic button_nxt;
  logic attn_ind_r;
  logic attn_ind_nxt;
  logic pwr_ind_r;
  logic pwr_ind_nxt;

  // Field values before packing
  logic [2:0] mps_field;
  logic [1:0] phantom_field;
  logic tag8_field;
  logic [2:0] l0s_field;
  logic [2:0] l1_field;

  // Register word before and after the reserved bits are forced to zero
  logic [31:0] word_raw;
  logic [31:0] cap_word;

  // Read path
  logic rd_hit;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  strap_capture u_strap (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .hp_strap_i(hp_strap_i),
    .fwd_bridge_i(fwd_bridge_i),
    .hp_en_o(hp_en),
    .fwd_o(fwd)
  );

  spl_capture u_spl (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .msg_i(spl_msg_i),
    .value_o(spl_value),
    .scale_o(spl_scale)
  );

  // Reserved payload codes fall back to the reset code, so a mistaken
  // parameter can never advertise an undefined payload size
  function automatic logic [2:0] legal_mps(input logic [2:0] code);
    case (code)
      3'h0: legal_mps = 3'h0;
      3'h1: legal_mps = 3'h1;
      3'h2: legal_mps = 3'h2;
      3'h3: legal_mps = 3'h3;
      3'h4: legal_mps = 3'h4;
      3'h5: legal_mps = 3'h5;
      default: legal_mps = `DEVCAP_MPS_RESET;
    endcase
  endfunction

  // Only the one double word of this register answers
  function automatic logic is_devcap(input logic [7:0] addr);
    is_devcap = (addr == `DEVCAP_OFFSET);
  endfunction

  // Places every field at its bit position
  function automatic logic [31:0] pack_word(
    input logic [2:0] mps,
    input logic [1:0] phantom,
    input logic tag8,
    input logic [2:0] l0s,
    input logic [2:0] l1,
    input logic button,
    input logic attn_ind,
    input logic pwr_ind,
    input logic [7:0] limit_value,
    input logic [1:0] limit_scale
  );
    pack_word = 32'h0000_0000;
    // Static capability fields
    pack_word[`DEVCAP_MPS_LSB +: 3] = mps;
    pack_word[`DEVCAP_PHANTOM_LSB +: 2] = phantom;
    pack_word[`DEVCAP_TAG8_BIT] = tag8;
    pack_word[`DEVCAP_L0S_LSB +: 3] = l0s;
    pack_word[`DEVCAP_L1_LSB +: 3] = l1;
    // Hot-plug presence fields
    pack_word[`DEVCAP_ABP_BIT] = button;
    pack_word[`DEVCAP_AIP_BIT] = attn_ind;
    pack_word[`DEVCAP_PIP_BIT] = pwr_ind;
    // Slot power limit fields
    pack_word[`DEVCAP_SPLV_LSB +: 8] = limit_value;
    pack_word[`DEVCAP_SPLS_LSB +: 2] = limit_scale;
  endfunction

  // Reserved bits are cleared once more after packing, so a field that is
  // widened by mistake cannot leak into them
  function automatic logic [31:0] clear_reserved(input logic [31:0] word);
    clear_reserved = word;
    clear_reserved[`DEVCAP_RSVD_LO_LSB +: 3] = 3'h0;
    clear_reserved[`DEVCAP_RSVD_HI_LSB +: 4] = 4'h0;
  endfunction

  // Codes the static fields hold from reset onward
  localparam logic [2:0] MPS_RESET_CODE = legal_mps(MPS_CODE);
  localparam logic [2:0] L0S_RESET_CODE = L0S_CODE;
  localparam logic [2:0] L1_RESET_CODE = L1_CODE;

  // Writes are ignored: the register is read-only to software, so even a
  // write that hits this offset leaves every code where reset put it
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (wr_i && is_devcap(addr_i))
    begin
      cfg_nxt = cfg_r;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_r.mps <= MPS_RESET_CODE;
      cfg_r.l0s_lat <= L0S_RESET_CODE;
      cfg_r.l1_lat <= L1_RESET_CODE;
    end
    else
    begin
      cfg_r <= cfg_nxt;
    end
  end

  // The button exists only on a forward bridge; the indicators follow the strap alone
  always_comb
  begin
    button_nxt = 1'b0;
    attn_ind_nxt = 1'b0;
    pwr_ind_nxt = 1'b0;
    if (hp_en)
    begin
      attn_ind_nxt = 1'b1;
      pwr_ind_nxt = 1'b1;
      if (fwd)
      begin
        button_nxt = 1'b1;
      end
    end
  end

  // One edge behind the strap capture; a read this early after reset is not expected
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      button_r <= 1'b0;
      attn_ind_r <= 1'b0;
      pwr_ind_r <= 1'b0;
    end
    else
    begin
      button_r <= button_nxt;
      attn_ind_r <= attn_ind_nxt;
      pwr_ind_r <= pwr_ind_nxt;
    end
  end

  always_comb
  begin
    mps_field = cfg_r.mps;
    phantom_field = `DEVCAP_PHANTOM_VAL;
    tag8_field = 1'b1;
    l0s_field = cfg_r.l0s_lat;
    l1_field = cfg_r.l1_lat;
  end

  always_comb
  begin
    word_raw = pack_word(
      mps_field,
      phantom_field,
      tag8_field,
      l0s_field,
      l1_field,
      button_r,
      attn_ind_r,
      pwr_ind_r,
      spl_value,
      spl_scale
    );
    cap_word = clear_reserved(word_raw);
  end

  always_comb
  begin
    rd_hit = rd_i && is_devcap(addr_i);
  end

  // Unmapped addresses read zero; read data stand for one cycle only
  always_comb
  begin
    if (rd_hit)
    begin
      rdata_nxt = cap_word;
    end
    else
    begin
      rdata_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign devcap_o = cap_word;
endmodule // device_capability

// *** hw/devcap_cfg.svh ***
// Constants for the device capability register block.
// Assumes inclusion by bare name from the hw folder.
`ifndef DEVCAP_CFG_SVH
`define DEVCAP_CFG_SVH

`define DEVCAP_OFFSET 8'hb4
`define DEVCAP_MPS_LSB 0
`define DEVCAP_MPS_RESET 3'h1
`define DEVCAP_PHANTOM_LSB 3
`define DEVCAP_PHANTOM_VAL 2'h0
`define DEVCAP_TAG8_BIT 5
`define DEVCAP_L0S_LSB 6
`define DEVCAP_L0S_RESET 3'h0
`define DEVCAP_L1_LSB 9
`define DEVCAP_L1_RESET 3'h0
`define DEVCAP_ABP_BIT 12
`define DEVCAP_AIP_BIT 13
`define DEVCAP_PIP_BIT 14
`define DEVCAP_RSVD_LO_LSB 15
`define DEVCAP_RSVD_HI_LSB 28
`define DEVCAP_SPLV_LSB 18
`define DEVCAP_SPLV_RESET 8'h00
`define DEVCAP_SPLS_LSB 26
`define DEVCAP_SPLS_RESET 2'h0

`endif

// *** hw/devcap_pkg.sv ***
// Types for the device capability register block.
// Assumes the cfg header supplies numeric constants.
package devcap_pkg;

  // Captured slot power limit message payload
  typedef struct packed {
    logic valid;
    logic [7:0] value;
    logic [1:0] scale;
  } spl_msg_t;

  // Static capability settings chosen by the integrator
  typedef struct packed {
    logic [2:0] mps;
    logic [2:0] l0s_lat;
    logic [2:0] l1_lat;
  } cap_cfg_t;

endpackage

// *** hw/strap_capture.sv ***
// Captures the hot-plug strap and bridge direction after reset release.
// Assumes the strap pins are stable around reset deassertion.
`timescale 1ns/1ps
module strap_capture
  import devcap_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic hp_strap_i,
  input wire logic fwd_bridge_i,
  output logic hp_en_o,
  output logic fwd_o
);
  logic done_r;
  logic done_nxt;
  logic hp_r;
  logic hp_nxt;
  logic fwd_r;
  logic fwd_nxt;

  // Capture once on the first edge after release, not in the reset branch
  always_comb
  begin
    done_nxt = 1'b1;
    hp_nxt = done_r ? hp_r : hp_strap_i;
    fwd_nxt = done_r ? fwd_r : fwd_bridge_i;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      done_r <= 1'b0;
      hp_r <= 1'b0;
      fwd_r <= 1'b0;
    end
    else
    begin
      done_r <= done_nxt;
      hp_r <= hp_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  assign hp_en_o = hp_r;
  assign fwd_o = fwd_r;
endmodule // strap_capture

// *** hw/spl_capture.sv ***
// Holds the slot power limit value and scale from received messages.
// Assumes one valid pulse per message with payload alongside.
`timescale 1ns/1ps
`include "devcap_cfg.svh"
module spl_capture
  import devcap_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input spl_msg_t msg_i,
  output logic [7:0] value_o,
  output logic [1:0] scale_o
);
  logic [7:0] value_r;
  logic [7:0] value_nxt;
  logic [1:0] scale_r;
  logic [1:0] scale_nxt;

  always_comb
  begin
    value_nxt = msg_i.valid ? msg_i.value : value_r;
    scale_nxt = msg_i.valid ? msg_i.scale : scale_r;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      value_r <= `DEVCAP_SPLV_RESET;
      scale_r <= `DEVCAP_SPLS_RESET;
    end
    else
    begin
      value_r <= value_nxt;
      scale_r <= scale_nxt;
    end
  end

  assign value_o = value_r;
  assign scale_o = scale_r;
endmodule // spl_capture

// *** testbench/devcap_asserts.sv ***
// Port checker for the device capability register.
// Assumes straps change only while reset is held.
`timescale 1ns/1ps
module devcap_asserts
  import devcap_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic hp_strap_i,
  input wire logic fwd_bridge_i,
  input spl_msg_t spl_msg_i,
  input wire logic [31:0] devcap_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // Presence bits settle two edges after release, so check from the third
  sequence settled_s; $past(nrst_i, 2); endsequence
  sequence load_s; spl_msg_i.valid; endsequence
  a_mps_code: assert property (devcap_o[2:0] == 3'h1) else $error("mps");
  a_no_phantom: assert property (devcap_o[4:3] == 2'h0) else $error("phantom");
  a_tag_bit: assert property (devcap_o[5]) else $error("tag");
  a_l0s_code: assert property (devcap_o[8:6] == 3'h0) else $error("l0s");
  a_l1_code: assert property (devcap_o[11:9] == 3'h0) else $error("l1");
  a_button_bit: assert property (settled_s |-> devcap_o[12] == (hp_strap_i & fwd_bridge_i))
    else $error("button");
  a_indicator_bits: assert property (settled_s |-> devcap_o[14:13] == {2{hp_strap_i}})
    else $error("indicators");
  a_limit_load: assert property (load_s |=> devcap_o[27:18] == $past({spl_msg_i.scale,
    spl_msg_i.value})) else $error("limit load");
  a_limit_hold: assert property (!spl_msg_i.valid |=> $stable(devcap_o[27:18]))
    else $error("limit hold");
  a_read_word: assert property (rd_i && addr_i == 8'hb4 |=> rdata_o == $past(devcap_o))
    else $error("read word");
  a_idle_zero: assert property (!(rd_i && addr_i == 8'hb4) |=> rdata_o == 32'h0000_0000)
    else $error("idle read data not zero");
endmodule // devcap_asserts
bind device_capability devcap_asserts devcap_asserts_inst(.mclk_i, .nrst_i, .addr_i, .rd_i,
  .rdata_o, .hp_strap_i, .fwd_bridge_i, .spl_msg_i, .devcap_o);

// *** testbench/testbench.sv ***
// Self-checking bench for the device capability register.
// Assumes the design's default capability codes.
`timescale 1ns/1ps
module testbench
  import devcap_pkg::*;
;
  logic mclk_i, nrst_i, wr_i, rd_i, hp_strap_i, fwd_bridge_i;
  logic pend = 1'b0;
  logic [7:0] addr_i, cur_v, a;
  logic [31:0] wdata_i, rdata_o, devcap_o;
  logic [1:0] cur_s;
  spl_msg_t spl_msg_i;
  logic [31:0] q[$];
  int err_total = 0;
  int n_tests = 0;
  device_capability device_capability_inst(.mclk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .hp_strap_i, .fwd_bridge_i, .spl_msg_i, .devcap_o);
  initial
  begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] expw(input logic [7:0] ad);
    expw = (ad != 8'hb4) ? 32'h0000_0000 : {4'h0, cur_s, cur_v, 3'h0, hp_strap_i, hp_strap_i,
      hp_strap_i & fwd_bridge_i, 6'h00, 1'b1, 5'h01};
  endfunction
  task automatic rd(input logic [7:0] ad);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= ad;
    q.push_back(expw(ad));
    @(posedge mclk_i);
    rd_i <= 1'b0;
  endtask
  task automatic wr;
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= 8'hb4;
    wdata_i <= $urandom;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic msg;
    @(posedge mclk_i);
    cur_v = 8'($urandom);
    cur_s = 2'($urandom);
    spl_msg_i <= '{1'b1, cur_v, cur_s};
    @(posedge mclk_i);
    spl_msg_i.valid <= 1'b0;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk_i) pend <= rd_i;
  always @(negedge mclk_i)
    if (pend)
    begin
      n_tests++;
      if (rdata_o !== q[0])
      begin
        err_total++;
        $display("wrong value at %0t: got %h want %h", $time, rdata_o, q[0]);
      end
      void'(q.pop_front());
    end
  initial
  begin
    void'($urandom(32'h28e5a922));
    {nrst_i, wr_i, rd_i, hp_strap_i, fwd_bridge_i} = '0;
    addr_i = '0;
    wdata_i = '0;
    spl_msg_i = '0;
    for (int i = 0; i < 4; i++)
    begin
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b0;
      {hp_strap_i, fwd_bridge_i} <= 2'(i);
      cur_v = 8'h00;
      cur_s = 2'h0;
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rd(8'hb4);
      wr;
      rd(8'hb4);
      a = 8'($urandom);
      rd(a == 8'hb4 ? 8'hb5 : a);
      msg;
      rd(8'hb4);
      msg;
      rd(8'hb4);
      $display("test %0d done", i);
    end
    repeat (3) @(posedge mclk_i);
    final_report;
  end
  // Whole run is about 120 cycles; the 2000-cycle limit leaves ample margin
  initial
  begin
    #200000;
    err_total++;
    final_report;
  end
endmodule // testbench
